// ---- logic/lkb_consts.svh ----
// Purpose: Offsets, fields, reset values and timing of the buffer.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Included by the buffer top and the table walker.
`ifndef LKB_CONSTS_SVH
`define LKB_CONSTS_SVH
// Register byte offsets
`define LKB_OFF_CTRL  8'h00
`define LKB_OFF_CR0   8'h04
`define LKB_OFF_CR1   8'h08
`define LKB_OFF_PURGE 8'h0C
`define LKB_OFF_STAT  8'h10
`define LKB_OFF_COUNT 8'h14
// Field positions
`define LKB_CTRL_DAT  0
`define LKB_CTRL_SEL  1
`define LKB_CTRL_EMU  2
`define LKB_CR0_PG    9:8
`define LKB_CR0_SG    12:11
`define LKB_CR1_LEN   27:24
`define LKB_CR1_STO   23:6
`define LKB_STAT_WALK 16
// Size encodings
`define LKB_PG_2K     2'h1
`define LKB_PG_4K     2'h2
`define LKB_SG_64K    2'h0
`define LKB_SG_1M     2'h2
// Reset values
`define LKB_RST_CR    32'h0000_0000
// Walk time and clock period
`define LKB_WALK_NS   4000
`define LKB_CLK_NS    5
// Exception address store location
`define LKB_LOC_XADDR 24'h000090
`endif

// ---- logic/lkb_pkg.sv ----
// Purpose: Types shared by the buffer top and the table walker.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package lkb_pkg;
   // Address class of a microcode request
   typedef enum logic [3:0] {
      LKB_C_INSTR   = 4'h0,
      LKB_C_BRANCH  = 4'h1,
      LKB_C_OPERAND = 4'h2,
      LKB_C_LRA     = 4'h3,
      LKB_C_EVENT   = 4'h4,
      LKB_C_REAL    = 4'h5,
      LKB_C_NOSTORE = 4'h6,
      LKB_C_IMPLIED = 4'h7,
      LKB_C_CONSOLE = 4'h8,
      LKB_C_PSTORE  = 4'h9,
      LKB_C_PSEL    = 4'hA
   } lkb_class_t;
   typedef enum logic [1:0] {
      LKB_X_NONE = 2'h0,
      LKB_X_SEG  = 2'h1,
      LKB_X_PAGE = 2'h2,
      LKB_X_SPEC = 2'h3
   } lkb_exc_t;
   typedef enum logic [1:0] {
      LKB_ST_IDLE = 2'b01,
      LKB_ST_WALK = 2'b10
   } lkb_state_t;
   typedef enum logic [3:0] {
      LKB_W_IDLE = 4'b0001,
      LKB_W_SEG  = 4'b0010,
      LKB_W_PAGE = 4'b0100,
      LKB_W_HOLD = 4'b1000
   } lkb_wstate_t;
endpackage

// ---- logic/lkb_walker.sv ----
// Purpose: Two-level segment/page table walk for one address.
// Assumes: vaddr, cr0, cr1 stay stable from start until done.
// Notes:   A good walk is stretched to the full walk time.
`include "lkb_consts.svh"
module lkb_walker #(
   parameter int WALK_CYC = 800
) (
   // Clock and reset
   input  logic              pclk,
   input  logic              presetn,
   // Walk request
   input  logic              start,
   input  logic [23:0]       vaddr,
   input  logic [31:0]       cr0,
   input  logic [31:0]       cr1,
   // Walk result
   output logic              done,
   output logic [23:0]       raddr,
   output logic [23:0]       entry,
   output lkb_pkg::lkb_exc_t exc,
   // Table read port
   output logic              mem_req,
   output logic [23:0]       mem_addr,
   input  logic              mem_ack,
   input  logic [31:0]       mem_rdata
);
   import lkb_pkg::*;
   localparam int CW = $clog2(WALK_CYC + 1);

   if (WALK_CYC < 1) begin : g_chk
      $error("WALK_CYC must be at least one");
   end

   lkb_wstate_t st;
   logic [CW-1:0] cnt;
   logic          pg4k;
   logic          seg1m;
   logic          spec_bad;
   logic [7:0]    sidx;
   logic [8:0]    pidx;
   logic [23:0]   seg_a;
   logic [23:0]   pt_a;
   logic [15:0]   pte;

   // Size decode and table entry addresses
   assign pg4k  = cr0[`LKB_CR0_PG] == `LKB_PG_4K;
   assign seg1m = cr0[`LKB_CR0_SG] == `LKB_SG_1M;
   assign spec_bad = !(pg4k || cr0[`LKB_CR0_PG] == `LKB_PG_2K) ||
                     !(seg1m || cr0[`LKB_CR0_SG] == `LKB_SG_64K);
   assign sidx = seg1m ? {4'h0, vaddr[23:20]} : vaddr[23:16];
   assign pidx = seg1m ? (pg4k ? {1'b0, vaddr[19:12]} : vaddr[19:11])
                       : (pg4k ? {5'h0, vaddr[15:12]}
                               : {4'h0, vaddr[15:11]});
   assign seg_a = {cr1[`LKB_CR1_STO], 6'h00} + {14'h0000, sidx, 2'b00};
   assign pt_a  = {mem_rdata[23:3], 3'h0} + {14'h0000, pidx, 1'b0};
   assign pte = mem_addr[1] ? mem_rdata[15:0] : mem_rdata[31:16];

   // Walk time counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (start) begin
         cnt <= '0;
      end else if (cnt != CW'(WALK_CYC)) begin
         cnt <= cnt + 1'b1;
      end
   end

   // Walk sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st  <= LKB_W_IDLE;
         exc <= LKB_X_NONE;
         {done, mem_req, raddr, entry, mem_addr} <= '0;
      end else begin
         done <= 1'b0;
         case (st)
            LKB_W_IDLE: if (start) begin
               entry <= seg_a;
               exc   <= LKB_X_NONE;
               // (R20) Exception ends walk
               if (spec_bad) begin
                  done <= 1'b1;
                  exc  <= LKB_X_SPEC;
               end else if (sidx[7:4] > cr1[`LKB_CR1_LEN]) begin
                  done <= 1'b1;
                  exc  <= LKB_X_SEG;
               end else begin
                  mem_req  <= 1'b1;
                  mem_addr <= seg_a;
                  st       <= LKB_W_SEG;
               end
            end
            LKB_W_SEG: if (mem_ack) begin
               mem_req <= 1'b0;
               st      <= LKB_W_IDLE;
               if (mem_rdata[0]) begin
                  done <= 1'b1;
                  exc  <= LKB_X_SEG;
               end else if (pidx[8:4] > {1'b0, mem_rdata[31:28]}) begin
                  done <= 1'b1;
                  exc  <= LKB_X_PAGE;
               end else begin
                  mem_req  <= 1'b1;
                  mem_addr <= pt_a;
                  entry    <= pt_a;
                  st       <= LKB_W_PAGE;
               end
            end
            LKB_W_PAGE: if (mem_ack) begin
               mem_req <= 1'b0;
               if (pte[2]) begin
                  done <= 1'b1;
                  exc  <= LKB_X_PAGE;
                  st   <= LKB_W_IDLE;
               end else begin
                  raddr <= pg4k ? {pte[15:4], vaddr[11:0]}
                                : {pte[15:3], vaddr[10:0]};
                  st    <= LKB_W_HOLD;
               end
            end
            LKB_W_HOLD: begin
               // (R4) Full walk time
               if (cnt >= CW'(WALK_CYC - 1)) begin
                  done <= 1'b1;
                  st   <= LKB_W_IDLE;
               end
            end
            default: st <= LKB_W_IDLE;
         endcase
      end
   end
endmodule

// ---- logic/lkb_top.sv ----
// Purpose: Fully associative lookaside buffer for dynamic translation.
// Assumes: One request at a time from microcode, all on pclk.
// Notes:   Hits and bypassed addresses answer one cycle after accept.
// Function
// (R1) Buffer is looked up before any table walk begins; explicit, console and panel switch walks skip it.
// (R2) All entries compared at once in one lookup.
// (R3) Match yields stored real address with no extra delay.
// (R4) Miss runs the two-level table walk, about four microseconds.
// (R5) Reset zeroes every entry's tag and parity bit.
// (R6) Purge operation invalidates all entries together.
// (R7) Mode off, control 1 change, size change, emulator purge.
// (R8) Software purges after invalidating a page table entry.
// (R9) Instruction, branch, operand, explicit and event addresses translate.
// (R10) Explicitly real addresses bypass translation.
// (R11) Non-storage address values pass untranslated.
// (R12) Implicit accesses use real addresses.
// (R13) Virtual address returned for storing to software.
// (R14) Explicit translate gives real address and entry address.
// (R15) Console virtual request walks tables, skipping the buffer.
// (R16) Console answer carries virtual, real or error.
// (R17) Panel store real; compare and counter set follow switch.
// (R18) Good walk fills least recently used entry.
// (R19) Entry holds page tag and 12 or 13 frame bits.
// (R20) Explicit fault sets condition code; implicit interrupts.
// (R21) Faulting walk leaves the buffer untouched.
// (R22) Hit address joins frame bits with byte displacement.
`include "lkb_consts.svh"
module lkb_top #(
   parameter int NENT     = 8,
   parameter int WALK_CYC = (`LKB_WALK_NS + `LKB_CLK_NS - 1) / `LKB_CLK_NS
) (
   // Clock and reset
   input  logic                pclk,
   input  logic                presetn,
   // APB slave
   input  logic                psel,
   input  logic                penable,
   input  logic                pwrite,
   input  logic [7:0]          paddr,
   input  logic [31:0]         pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   // Microcode request
   input  logic                req_valid,
   input  lkb_pkg::lkb_class_t req_class,
   input  logic [23:0]         req_vaddr,
   output logic                req_ready,
   input  logic                buffer_purge_op,
   // Answer
   output logic                rsp_valid,
   output logic [23:0]         rsp_vaddr,
   output logic [23:0]         rsp_raddr,
   output logic [23:0]         rsp_entry,
   output lkb_pkg::lkb_exc_t   rsp_exc,
   output logic [1:0]          rsp_cc,
   output logic [23:0]         rsp_store_loc,
   output logic                prog_int,
   // Table read port
   output logic                mem_req,
   output logic [23:0]         mem_addr,
   input  logic                mem_ack,
   input  logic [31:0]         mem_rdata
);
   import lkb_pkg::*;
   localparam int IW = $clog2(NENT);
   if (NENT < 2 || NENT > 16 || (NENT & (NENT - 1)) != 0) begin : g_chk
      $error("NENT must be a power of two from 2 to 16");
   end
   // Control state
   logic          dat_on, sel_virt, fill_ok, drop_fill, w_start;
   logic [31:0]   cr0, cr1, rd_word;
   lkb_state_t    state;
   lkb_class_t    cls;
   logic [15:0]   hit_cnt, miss_cnt;
   // Buffer entries
   logic [12:0]   tag   [NENT];
   logic [12:0]   frame [NENT];
   logic          par   [NENT];
   logic [IW-1:0] age   [NENT];
   // Lookup and walker results
   logic          pg4k, hit, via_buf, walk_only, need_walk, accept;
   logic          purge, do_fill, touch, w_done, apb_wr, apb_setup, mapped;
   logic [IW-1:0] hit_idx, victim, touch_idx;
   logic [23:0]   va, hit_real, w_raddr, w_entry;
   lkb_exc_t      w_exc;
   // Page tag of an address, low bit dropped for 4K pages
   function automatic logic [12:0] tag_of(logic [23:0] a, logic p4);
      tag_of = p4 ? {a[23:12], 1'b0} : a[23:11];
   endfunction
   assign pg4k      = cr0[`LKB_CR0_PG] == `LKB_PG_4K;
   assign accept    = req_ready && req_valid;
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pready && pwrite;
   // (R2) Parallel compare
   always_comb begin
      hit     = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < NENT; i++) begin
         if (par[i] && tag[i] == tag_of(req_vaddr, pg4k)) begin
            hit     = 1'b1;
            hit_idx = IW'(i);
         end
      end
   end

   // (R22) Frame joined with displacement
   assign hit_real = pg4k ? {frame[hit_idx][12:1], req_vaddr[11:0]}
                          : {frame[hit_idx], req_vaddr[10:0]};

   // Least recently used entry
   always_comb begin
      victim = '0;
      for (int i = 0; i < NENT; i++) begin
         if (age[i] == IW'(NENT - 1)) begin
            victim = IW'(i);
         end
      end
   end

   // Address class routing
   always_comb begin
      via_buf   = 1'b0;
      walk_only = 1'b0;
      case (req_class)
         // (R9) Translated classes
         LKB_C_INSTR, LKB_C_BRANCH, LKB_C_OPERAND, LKB_C_EVENT: begin
            via_buf = dat_on;
         end
         // (R14) (R15) Explicit and console walk
         LKB_C_LRA, LKB_C_CONSOLE: walk_only = 1'b1;
         // (R17) Switch picks virtual
         LKB_C_PSEL: walk_only = sel_virt;
         // (R10) (R11) (R12) (R17) Real or unused
         default: walk_only = 1'b0;
      endcase
   end
   // (R1) Buffer before walk
   assign need_walk = (via_buf && !hit) || walk_only;

   // (R7) Clearing events
   always_comb begin
      purge = buffer_purge_op; // (R6) purge operation
      if (apb_wr) begin
         case (paddr)
            `LKB_OFF_CTRL: purge = purge || pwdata[`LKB_CTRL_EMU] ||
                                   (dat_on && !pwdata[`LKB_CTRL_DAT]);
            `LKB_OFF_CR0: purge = purge ||
                  pwdata[`LKB_CR0_PG] != cr0[`LKB_CR0_PG] ||
                  pwdata[`LKB_CR0_SG] != cr0[`LKB_CR0_SG];
            `LKB_OFF_CR1: purge = purge || pwdata != cr1;
            `LKB_OFF_PURGE: purge = 1'b1;
            default: purge = buffer_purge_op;
         endcase
      end
   end
   // (R18) (R21) Fill only after good walk
   assign do_fill = state == LKB_ST_WALK && w_done && w_exc == LKB_X_NONE
                    && fill_ok && !drop_fill && !purge;
   assign touch     = (accept && via_buf && hit) || do_fill;
   assign touch_idx = do_fill ? victim : hit_idx;

   // Recency ages, zero is newest
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NENT; i++) begin
            age[i] <= IW'(i);
         end
      end else if (touch) begin
         for (int i = 0; i < NENT; i++) begin
            if (IW'(i) == touch_idx) begin
               age[i] <= '0;
            end else if (age[i] < age[touch_idx]) begin
               age[i] <= age[i] + 1'b1;
            end
         end
      end
   end

   // Entry contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // (R5) Reset clears tags
         for (int i = 0; i < NENT; i++) begin
            tag[i]   <= 13'h0000;
            frame[i] <= 13'h0000;
            par[i]   <= 1'b0;
         end
      end else if (purge) begin
         // (R6) (R7) Clear all
         for (int i = 0; i < NENT; i++) begin
            tag[i] <= 13'h0000;
            par[i] <= 1'b0;
         end
      end else if (do_fill) begin
         // (R19) Tag and frame
         tag[victim]   <= tag_of(va, pg4k);
         frame[victim] <= tag_of(w_raddr, pg4k);
         par[victim]   <= 1'b1;
      end
   end

   // Request sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= LKB_ST_IDLE;
         req_ready <= 1'b1;
         cls       <= LKB_C_REAL;
         {va, fill_ok, drop_fill, w_start} <= '0;
      end else begin
         w_start <= 1'b0;
         case (state)
            LKB_ST_IDLE: begin
               // (R4) Miss starts walk
               if (accept && need_walk) begin
                  state     <= LKB_ST_WALK;
                  req_ready <= 1'b0;
                  cls       <= req_class;
                  va        <= req_vaddr;
                  fill_ok   <= req_class != LKB_C_CONSOLE &&
                               req_class != LKB_C_PSEL;
                  drop_fill <= purge;
                  w_start   <= 1'b1;
               end
            end
            LKB_ST_WALK: begin
               if (purge) begin
                  drop_fill <= 1'b1;
               end
               if (w_done) begin
                  state     <= LKB_ST_IDLE;
                  req_ready <= 1'b1;
               end
            end
            default: begin
               state     <= LKB_ST_IDLE;
               req_ready <= 1'b1;
            end
         endcase
      end
   end

   // Answer to microcode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_exc <= LKB_X_NONE;
         {rsp_valid, rsp_vaddr, rsp_raddr, rsp_entry} <= '0;
         {rsp_cc, rsp_store_loc, prog_int} <= '0;
      end else begin
         rsp_valid <= 1'b0;
         prog_int  <= 1'b0;
         if (accept && !need_walk) begin
            // (R3) Hit answers at once
            rsp_valid     <= 1'b1;
            rsp_vaddr     <= req_vaddr;
            rsp_raddr     <= via_buf ? hit_real : req_vaddr;
            rsp_exc       <= LKB_X_NONE;
            {rsp_entry, rsp_cc, rsp_store_loc} <= '0;
         end else if (state == LKB_ST_WALK && w_done) begin
            rsp_valid <= 1'b1;
            // (R13) (R16) Virtual echoed, error replaces real
            rsp_vaddr <= va;
            rsp_raddr <= w_exc == LKB_X_NONE ? w_raddr : 24'h000000;
            // (R14) Entry address reported
            rsp_entry <= w_entry;
            rsp_exc   <= w_exc;
            // (R20) Code or interruption
            rsp_cc    <= cls == LKB_C_LRA ? w_exc : 2'h0;
            prog_int  <= fill_ok && w_exc != LKB_X_NONE &&
                         (cls != LKB_C_LRA || w_exc == LKB_X_SPEC);
            rsp_store_loc <= (fill_ok && cls != LKB_C_LRA &&
                             (w_exc == LKB_X_SEG || w_exc == LKB_X_PAGE))
                             ? `LKB_LOC_XADDR : 24'h000000;
         end
      end
   end
   // Lookup statistics
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {hit_cnt, miss_cnt} <= '0;
      end else if (apb_wr && paddr == `LKB_OFF_COUNT) begin
         {hit_cnt, miss_cnt} <= '0;
      end else if (accept && via_buf && hit) begin
         hit_cnt <= hit_cnt + 1'b1;
      end else if (accept && via_buf) begin
         miss_cnt <= miss_cnt + 1'b1;
      end
   end
   // Software control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {dat_on, sel_virt} <= 2'b00;
         cr0      <= `LKB_RST_CR;
         cr1      <= `LKB_RST_CR;
      end else if (apb_wr) begin
         case (paddr)
            `LKB_OFF_CTRL: begin
               dat_on   <= pwdata[`LKB_CTRL_DAT];
               sel_virt <= pwdata[`LKB_CTRL_SEL];
            end
            `LKB_OFF_CR0: cr0 <= pwdata;
            `LKB_OFF_CR1: cr1 <= pwdata;
            default: dat_on <= dat_on;
         endcase
      end
   end

   // Read mux and address decode
   always_comb begin
      rd_word = 32'h0000_0000;
      mapped  = 1'b1;
      case (paddr)
         `LKB_OFF_CTRL: begin
            rd_word[`LKB_CTRL_DAT] = dat_on;
            rd_word[`LKB_CTRL_SEL] = sel_virt;
         end
         `LKB_OFF_CR0:   rd_word = cr0;
         `LKB_OFF_CR1:   rd_word = cr1;
         `LKB_OFF_PURGE: rd_word = 32'h0000_0000;
         `LKB_OFF_STAT: begin
            for (int i = 0; i < NENT; i++) begin
               rd_word[i] = par[i];
            end
            rd_word[`LKB_STAT_WALK] = state == LKB_ST_WALK;
         end
         `LKB_OFF_COUNT: rd_word = {miss_cnt, hit_cnt};
         default:        mapped  = 1'b0;
      endcase
   end
   // APB answer, one wait-free access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {pready, pslverr, prdata} <= '0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup && !mapped;
         if (apb_setup && !pwrite) begin
            prdata <= rd_word;
         end
      end
   end

   // Table walker
   lkb_walker #(.WALK_CYC(WALK_CYC)) u_walk (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (w_start),
      .vaddr     (va),
      .cr0       (cr0),
      .cr1       (cr1),
      .done      (w_done),
      .raddr     (w_raddr),
      .entry     (w_entry),
      .exc       (w_exc),
      .mem_req   (mem_req),
      .mem_addr  (mem_addr),
      .mem_ack   (mem_ack),
      .mem_rdata (mem_rdata)
   );
endmodule

// ---- tb/lkb_mem_model.sv ----
// Purpose: Table storage behind the walker read port.
// Assumes: Segment table below 0x2000, page table from 0x2000.
// Notes:   Data lines carry inverted junk outside an acknowledge.
module lkb_mem_model (
   // Clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // Zero or five wait cycles
   input  logic        slow,
   // Table read port
   input  logic        mem_req,
   input  logic [23:0] mem_addr,
   output logic        mem_ack,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  cnt;
   logic [15:0] half;
   // Frame AB plus page index, page F marked missing
   assign half = {8'hAB, mem_addr[4:1], 1'b0, mem_addr[4:1] == 4'hF, 2'h0};
   // Acknowledge after the wait, scramble data otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 3'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= 32'h0;
      end else if (mem_req && !mem_ack && cnt >= (slow ? 3'h5 : 3'h0)) begin
         cnt       <= 3'h0;
         mem_ack   <= 1'b1;
         mem_rdata <= mem_addr[13] ? {half, half} : 32'h0000_2000;
      end else begin
         cnt       <= (mem_req && !mem_ack) ? cnt + 3'h1 : 3'h0;
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ---- tb/lkb_top_properties.sv ----
// Purpose: Port-level checks of the lookaside buffer top.
// Assumes: One clock domain, reset low is inactive time.
// Notes:   Tracks the last accepted class and address.
module lkb_props (
   input logic                pclk,
   input logic                presetn,
   input logic                req_valid,
   input lkb_pkg::lkb_class_t req_class,
   input logic [23:0]         req_vaddr,
   input logic                req_ready,
   input logic                rsp_valid,
   input logic [23:0]         rsp_vaddr,
   input logic [23:0]         rsp_raddr,
   input lkb_pkg::lkb_exc_t   rsp_exc,
   input logic [1:0]          rsp_cc,
   input logic                prog_int,
   input logic                mem_req,
   input logic [23:0]         mem_addr,
   input logic                mem_ack
);
   import lkb_pkg::*;
   logic [3:0]  lc;
   logic [23:0] lv;
   logic        acc;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc = req_valid && req_ready;
   // Last accepted request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lc <= 4'h0;
         lv <= 24'h0;
      end else if (acc) begin
         lc <= req_class;
         lv <= req_vaddr;
      end
   end
   a_real_bypass: assert property (acc && req_class == LKB_C_REAL
      |=> rsp_valid && rsp_raddr == $past(req_vaddr)) else $error("real");
   a_nostore_bypass: assert property (acc && req_class == LKB_C_NOSTORE
      |=> rsp_valid && rsp_raddr == $past(req_vaddr)) else $error("nostore");
   a_implied_bypass: assert property (acc && req_class == LKB_C_IMPLIED
      |=> rsp_valid && rsp_raddr == $past(req_vaddr)) else $error("implied");
   a_vaddr_echo: assert property (rsp_valid |-> rsp_vaddr == lv)
      else $error("echo");
   a_console_walks: assert property (acc && req_class == LKB_C_CONSOLE
      |=> !req_ready) else $error("console");
   a_fault_noaddr: assert property (rsp_valid && rsp_exc != LKB_X_NONE
      |-> rsp_raddr == 24'h0) else $error("fault addr");
   a_cc_explicit: assert property (rsp_valid
      |-> rsp_cc == ((lc == LKB_C_LRA) ? rsp_exc : 2'h0)) else $error("cc");
   a_int_pulse: assert property (prog_int |-> rsp_valid)
      else $error("int");
   a_mem_hold: assert property (mem_req && !mem_ack
      |=> mem_req && $stable(mem_addr)) else $error("mem hold");
   c_hit: cover property (acc ##1 rsp_valid && rsp_exc == LKB_X_NONE);
   c_fault: cover property (rsp_valid && rsp_exc == LKB_X_PAGE);
   c_walk: cover property (mem_req && mem_ack);
endmodule
bind lkb_top lkb_props u_props (.*);

// ---- tb/tb_lkb_top.sv ----
// Purpose: Self-checking bench for the lookaside buffer top.
// Assumes: Walk time shortened to WC cycles.
// Notes:   Tables come from the memory model.
module tb_lkb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lkb_pkg::*;
   localparam int WC = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        req_valid, req_ready, buffer_purge_op, rsp_valid, prog_int;
   logic        mem_req, mem_ack, slow, err;
   logic [7:0]  paddr;
   logic [1:0]  rsp_cc;
   logic [31:0] pwdata, prdata, mem_rdata, rd;
   logic [23:0] req_vaddr, rsp_vaddr, rsp_raddr, rsp_entry;
   logic [23:0] rsp_store_loc, mem_addr;
   lkb_class_t  req_class;
   lkb_exc_t    rsp_exc;
   int          error_cnt, cmp_count, n;
   lkb_top #(.WALK_CYC(WC)) DUT (.*);
   lkb_mem_model u_mem (.*);
   // 200 MHz clock
   always #2.5 pclk = ~pclk;
   task automatic chk(input string s, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Request and answer; k 1 expects a hit, k 2 a full walk
   task automatic tr(input lkb_class_t c, input logic [23:0] va, ra,
                     input lkb_exc_t x, input int k);
      req_valid <= 1'b1;
      req_class <= c;
      req_vaddr <= va;
      do @(posedge pclk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp_valid !== 1'b1);
      chk("raddr", ra, rsp_raddr);
      chk("exc", x, rsp_exc);
      chk("vaddr", va, rsp_vaddr);
      if (k == 1)
         chk("hit", 1, n);
      if (k == 2)
         chk("walk", 1, n > WC);
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      complete_run();
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, req_valid, buffer_purge_op} = '0;
      {paddr, pwdata, req_vaddr, slow} = '0;
      req_class = LKB_C_INSTR;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("ready", 1, req_ready);
      apb(1'b1, 8'h04, 32'h200);
      apb(1'b1, 8'h08, 32'h1000);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk("cr0", 32'h200, rd);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 1, err);
      tr(LKB_C_INSTR, 24'h000000, 24'hAB0000, LKB_X_NONE, 2);
      tr(LKB_C_INSTR, 24'h000123, 24'hAB0123, LKB_X_NONE, 1);
      tr(LKB_C_EVENT, 24'h000789, 24'hAB0789, LKB_X_NONE, 1);
      slow <= 1'b1;
      tr(LKB_C_BRANCH, 24'h012345, 24'hAB2345, LKB_X_NONE, 2);
      slow <= 1'b0;
      tr(LKB_C_INSTR, 24'h00F010, 24'h0, LKB_X_PAGE, 0);
      chk("loc", 24'h000090, rsp_store_loc);
      chk("int", 1, prog_int);
      tr(LKB_C_INSTR, 24'h00F010, 24'h0, LKB_X_PAGE, 0);
      tr(LKB_C_LRA, 24'h200000, 24'h0, LKB_X_SEG, 0);
      chk("cc", 2, {rsp_cc, prog_int});
      tr(LKB_C_LRA, 24'h000010, 24'hAB0010, LKB_X_NONE, 2);
      chk("entry", 24'h002000, rsp_entry);
      tr(LKB_C_CONSOLE, 24'h000020, 24'hAB0020, LKB_X_NONE, 2);
      for (int i = 0; i < 4; i++)
         tr(lkb_class_t'(i < 3 ? 5 + i : 9), 24'h00F123, 24'h00F123,
            LKB_X_NONE, 1);
      apb(1'b1, 8'h00, 32'h3);
      tr(LKB_C_PSEL, 24'h00F123, 24'h0, LKB_X_PAGE, 0);
      apb(1'b1, 8'h00, 32'h0);
      tr(LKB_C_PSEL, 24'h00F123, 24'h00F123, LKB_X_NONE, 1);
      tr(LKB_C_INSTR, 24'h00F123, 24'h00F123, LKB_X_NONE, 1);
      tr(LKB_C_CONSOLE, 24'h000020, 24'hAB0020, LKB_X_NONE, 2);
      apb(1'b1, 8'h00, 32'h1);
      for (int k = 0; k < 4; k++) begin
         tr(LKB_C_OPERAND, 24'h000456, 24'hAB0456, LKB_X_NONE, 0);
         buffer_purge_op <= (k == 0);
         @(posedge pclk);
         buffer_purge_op <= 1'b0;
         if (k > 0)
            apb(1'b1, (k == 1) ? 8'h0C : (k == 2) ? 8'h00 : 8'h08,
                (k == 2) ? 32'h5 : 32'h0F00_1000);
         tr(LKB_C_OPERAND, 24'h000456, 24'hAB0456, LKB_X_NONE, 2);
      end
      for (int i = 1; i < 8; i++)
         tr(LKB_C_OPERAND, {8'h0, i[3:0], 12'h0}, {8'hAB, i[3:0], 12'h0},
            LKB_X_NONE, 2);
      tr(LKB_C_OPERAND, 24'h000000, 24'hAB0000, LKB_X_NONE, 1);
      tr(LKB_C_OPERAND, 24'h008000, 24'hAB8000, LKB_X_NONE, 2);
      tr(LKB_C_OPERAND, 24'h000004, 24'hAB0004, LKB_X_NONE, 1);
      tr(LKB_C_OPERAND, 24'h001000, 24'hAB1000, LKB_X_NONE, 2);
      complete_run();
   end
endmodule
